// ===== src/sram_cmd_regs.svh
// named constants for the burst-of-two ddr sram command port
`ifndef SRAM_CMD_REGS_SVH
`define SRAM_CMD_REGS_SVH

`define LANE_W          9
`define ADDR_W_X18      20
`define LANES_X18       2
`define BURST_STEP      1'h1
`define BANK_EVEN       1'h0
`define BANK_ODD        1'h1
`define OE_IDLE         1'h0
`define FLAG_CLEAR      1'h0
`define FLAG_SET        1'h1
`define RD_LAT_NORMAL   2
`define RD_LAT_BYPASS   1

`endif

// ===== src/sram_cmd_pkg.sv
// types shared by the burst-of-two ddr sram command port
package sram_cmd_pkg;

    typedef enum logic [1:0] {
        CMD_NOP,
        CMD_READ,
        CMD_WRITE
    } cmd_t;

endpackage : sram_cmd_pkg

// ===== src/sram_bank.sv
// one storage bank: byte-lane write port, registered read port
`timescale 1ns/100ps
`default_nettype none

module sram_bank #(
    parameter int ROW_W  = 19,
    parameter int LANES  = 2,
    parameter int LANE_W = 9
) (
    input  wire logic                      clock,
    input  wire logic                      ce,
    input  wire logic [LANES-1:0]          writeLaneEn,
    input  wire logic [ROW_W-1:0]          writeRow,
    input  wire logic [LANES*LANE_W-1:0]   writeData,
    input  wire logic                      readEn,
    input  wire logic [ROW_W-1:0]          readRow,
    output logic      [LANES*LANE_W-1:0]   readData
);

    logic [LANES*LANE_W-1:0] store [0:(1<<ROW_W)-1];

    // lanes are written independently so a masked lane keeps its old contents;
    // one process owns the whole array, as separate writers per lane are illegal
    always_ff @(posedge clock) begin
        if (ce) begin
            for (int lane = 0; lane < LANES; lane++) begin
                if (writeLaneEn[lane]) begin
                    store[writeRow][lane*LANE_W +: LANE_W] <= writeData[lane*LANE_W +: LANE_W];
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (ce && readEn) begin
            readData <= store[readRow];
        end
    end

endmodule : sram_bank

`default_nettype wire

// ===== src/burst2_ddr_sram_cmd_port.sv
// command decode, burst addressing and data-beat timing of the burst-of-two ddr sram
`timescale 1ns/100ps
`default_nettype none
`include "sram_cmd_regs.svh"

module burst2_ddr_sram_cmd_port #(
    parameter int ADDR_W = `ADDR_W_X18,
    parameter int LANES  = `LANES_X18,
    parameter int LANE_W = `LANE_W
) (
    input  wire logic                      clock,
    input  wire logic                      srst,
    input  wire logic                      ce,
    input  wire logic                      cmdLoadN,
    input  wire logic                      readWriteSel,
    input  wire logic [ADDR_W-1:0]         addr,
    input  wire logic                      dllOffN,
    input  wire logic [LANES*LANE_W-1:0]   dqIn0,
    input  wire logic [LANES*LANE_W-1:0]   dqIn1,
    input  wire logic [LANES-1:0]          byteEnBeat0N,
    input  wire logic [LANES-1:0]          byteEnBeat1N,
    output logic      [LANES*LANE_W-1:0]   dqOut0,
    output logic      [LANES*LANE_W-1:0]   dqOut1,
    output logic                           dqOe,
    output logic                           readValidOut,
    output logic                           echoClk
);

    localparam int DATA_W = LANES * LANE_W;
    localparam int ROW_W  = ADDR_W - 1;

    ////////////////////////////////////////////////////////////////////////////
    // command decode

    sram_cmd_pkg::cmd_t cmd;
    logic               readIssue;
    logic               writeIssue;

    always_comb begin
        if (cmdLoadN) begin
            cmd = sram_cmd_pkg::CMD_NOP;
        end else if (readWriteSel) begin
            cmd = sram_cmd_pkg::CMD_READ;
        end else begin
            cmd = sram_cmd_pkg::CMD_WRITE;
        end
    end

    assign readIssue  = (cmd == sram_cmd_pkg::CMD_READ);
    assign writeIssue = (cmd == sram_cmd_pkg::CMD_WRITE);

    ////////////////////////////////////////////////////////////////////////////
    // read pipeline: stage 1 is the bank read register, stage 2 the output register

    logic              rdStage1Reg;
    logic              rdLsb1Reg;
    logic              rdStage2Reg;
    logic [DATA_W-1:0] out2Beat0Reg;
    logic [DATA_W-1:0] out2Beat1Reg;
    logic [DATA_W-1:0] bankEvenRead;
    logic [DATA_W-1:0] bankOddRead;
    logic [DATA_W-1:0] beat0Mem;
    logic [DATA_W-1:0] beat1Mem;

    always_ff @(posedge clock) begin
        if (srst) begin
            rdStage1Reg <= `FLAG_CLEAR;
            rdLsb1Reg   <= `BANK_EVEN;
        end else if (ce) begin
            rdStage1Reg <= readIssue;
            rdLsb1Reg   <= addr[0];
        end
    end

    // the even and odd words of a pair sit in separate banks, so both beats read at once
    assign beat0Mem = (rdLsb1Reg == `BANK_ODD) ? bankOddRead : bankEvenRead;
    assign beat1Mem = (rdLsb1Reg == `BANK_ODD) ? bankEvenRead : bankOddRead;

    always_ff @(posedge clock) begin
        if (srst) begin
            rdStage2Reg <= `FLAG_CLEAR;
        end else if (ce) begin
            rdStage2Reg <= rdStage1Reg;
        end
    end

    always_ff @(posedge clock) begin
        if (ce && rdStage1Reg) begin
            out2Beat0Reg <= beat0Mem;
            out2Beat1Reg <= beat1Mem;
        end
    end

    // bypass mode takes the bank register itself, one cycle earlier; the mode pin should
    // only change while no read is in flight, or a window may be doubled or lost
    always_comb begin
        if (dllOffN) begin
            dqOut0 = out2Beat0Reg;
            dqOut1 = out2Beat1Reg;
            dqOe   = rdStage2Reg;
        end else begin
            dqOut0 = beat0Mem;
            dqOut1 = beat1Mem;
            dqOe   = rdStage1Reg;
        end
    end

    assign readValidOut = dqOe;

    always_ff @(posedge clock) begin
        if (srst) begin
            echoClk <= `FLAG_CLEAR;
        end else if (ce) begin
            echoClk <= ~echoClk;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write path: address held one cycle, beats taken in the next cycle

    logic              wrPendReg;
    logic              wrLsbReg;
    logic [ROW_W-1:0]  wrRowReg;
    logic [LANES-1:0]  laneEnBeat0;
    logic [LANES-1:0]  laneEnBeat1;
    logic [LANES-1:0]  weEven;
    logic [LANES-1:0]  weOdd;
    logic [DATA_W-1:0] dataEven;
    logic [DATA_W-1:0] dataOdd;

    always_ff @(posedge clock) begin
        if (srst) begin
            wrPendReg <= `FLAG_CLEAR;
        end else if (ce) begin
            wrPendReg <= writeIssue;
        end
    end

    always_ff @(posedge clock) begin
        if (ce && writeIssue) begin
            wrRowReg <= addr[ADDR_W-1:1];
            wrLsbReg <= addr[0];
        end
    end

    // each beat carries its own enables; all high leaves that beat unwritten
    assign laneEnBeat0 = wrPendReg ? ~byteEnBeat0N : '0;
    assign laneEnBeat1 = wrPendReg ? ~byteEnBeat1N : '0;

    always_comb begin
        if (wrLsbReg == `BANK_ODD) begin
            weOdd    = laneEnBeat0;
            dataOdd  = dqIn0;
            weEven   = laneEnBeat1;
            dataEven = dqIn1;
        end else begin
            weEven   = laneEnBeat0;
            dataEven = dqIn0;
            weOdd    = laneEnBeat1;
            dataOdd  = dqIn1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // storage; a low clock enable freezes everything so the bus holds its state

    sram_bank #(.ROW_W(ROW_W), .LANES(LANES), .LANE_W(LANE_W)) u_bank_even (
        .clock       (clock),
        .ce          (ce),
        .writeLaneEn (weEven),
        .writeRow    (wrRowReg),
        .writeData   (dataEven),
        .readEn      (readIssue),
        .readRow     (addr[ADDR_W-1:1]),
        .readData    (bankEvenRead)
    );

    sram_bank #(.ROW_W(ROW_W), .LANES(LANES), .LANE_W(LANE_W)) u_bank_odd (
        .clock       (clock),
        .ce          (ce),
        .writeLaneEn (weOdd),
        .writeRow    (wrRowReg),
        .writeData   (dataOdd),
        .readEn      (readIssue),
        .readRow     (addr[ADDR_W-1:1]),
        .readData    (bankOddRead)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst || !ce);

    sequence s_read_cmd;
        !cmdLoadN && readWriteSel;
    endsequence

    sequence s_write_cmd;
        !cmdLoadN && !readWriteSel;
    endsequence

    a_read_latency: assert property (s_read_cmd ##0 dllOffN ##1 dllOffN |-> ##1 (dqOe && readValidOut))
        else $error("read window missing two cycles after read");

    a_dll_bypass: assert property (s_read_cmd ##0 !dllOffN |-> ##1 (dqOe || dllOffN))
        else $error("bypass read window missing one cycle after read");

    a_nop_quiet: assert property (cmdLoadN |=> !rdStage1Reg && !wrPendReg)
        else $error("no-operation started a transfer");

    a_drive_window: assert property (dqOe && dllOffN |-> $past(readIssue, 2))
        else $error("bus driven outside a read window");

    a_abort_beat: assert property (wrPendReg && (&byteEnBeat0N) |-> ((wrLsbReg ? weOdd : weEven) == '0))
        else $error("aborted beat still wrote");

    a_lane_write: assert property (wrPendReg && !byteEnBeat1N[LANES-1] |-> (wrLsbReg ? weEven[LANES-1] : weOdd[LANES-1]))
        else $error("enabled lane of second beat not written");

    a_read_write: assert property (s_read_cmd ##1 s_write_cmd |=> wrPendReg && rdStage2Reg)
        else $error("write after read lost");

    property p_clock_stop;
        @(posedge clock) disable iff (srst)
        !ce |=> $stable(rdStage2Reg) && $stable(out2Beat0Reg) && $stable(out2Beat1Reg);
    endproperty

    a_clock_stop: assert property (p_clock_stop)
        else $error("output state moved while stopped");

endmodule : burst2_ddr_sram_cmd_port

`default_nettype wire

// ===== verif/sram_ctrl_model.sv
// controller-side model: issues commands and the late write beats
`timescale 1ns/100ps
`default_nettype none

module sram_ctrl_model (
    input  wire logic        clock,
    input  wire logic        ce,
    input  wire logic        reqOn,
    input  wire logic        reqRead,
    input  wire logic [19:0] reqAddr,
    input  wire logic [35:0] reqData,
    input  wire logic [3:0]  reqBeN,
    output logic             cmdLoadN,
    output logic             readWriteSel,
    output logic      [19:0] addr,
    output logic      [17:0] dqIn0,
    output logic      [17:0] dqIn1,
    output logic      [1:0]  byteEnBeat0N,
    output logic      [1:0]  byteEnBeat1N
);
    assign cmdLoadN     = !reqOn;
    assign readWriteSel = reqRead;
    assign addr         = reqAddr;

    ////////////////////////////////////////////////////////////
    initial {dqIn1, dqIn0, byteEnBeat1N, byteEnBeat0N} = '0;
    // outside a write beat the lines churn, so stale data can never pass for a write
    always @(posedge clock) begin
        if (ce) begin
            if (!cmdLoadN && !readWriteSel)
                {dqIn1, dqIn0, byteEnBeat1N, byteEnBeat0N} <= {reqData, reqBeN};
            else
                {dqIn1, dqIn0, byteEnBeat1N, byteEnBeat0N} <= ~{dqIn1, dqIn0, byteEnBeat1N, byteEnBeat0N};
        end
    end
endmodule : sram_ctrl_model
`default_nettype wire

// ===== verif/burst2_ddr_sram_cmd_port_bench.sv
// self-checking bench for the burst-of-two sram command port
`timescale 1ns/100ps
`default_nettype none

module burst2_ddr_sram_cmd_port_bench;
    typedef struct packed {logic v; logic [17:0] d0; logic [17:0] d1;} beat_t;
    logic        clock = 0, srst = 1, ce = 1, dllOffN = 1, reqOn = 0, reqRead = 0;
    logic [19:0] reqAddr = '0, base, wAddr, addr;
    logic [35:0] reqData = '0;
    logic [3:0]  reqBeN = '1;
    logic        cmdLoadN, readWriteSel, dqOe, readValidOut, echoClk, echoExp, wPend;
    logic [17:0] dqIn0, dqIn1, dqOut0, dqOut1;
    logic [1:0]  byteEnBeat0N, byteEnBeat1N;
    logic [17:0] refMem [logic [19:0]];
    beat_t       pipe [3];
    int          lat = 1, errTotal = 0, samplesChecked = 0, cycles = 0;

    sram_ctrl_model sram_ctrl_model_i (.clock, .ce, .reqOn, .reqRead, .reqAddr, .reqData, .reqBeN,
        .cmdLoadN, .readWriteSel, .addr, .dqIn0, .dqIn1, .byteEnBeat0N, .byteEnBeat1N);
    burst2_ddr_sram_cmd_port burst2_ddr_sram_cmd_port_i (.clock, .srst, .ce, .cmdLoadN, .readWriteSel,
        .addr, .dllOffN, .dqIn0, .dqIn1, .byteEnBeat0N, .byteEnBeat1N, .dqOut0, .dqOut1, .dqOe,
        .readValidOut, .echoClk);

    always #20 clock = !clock;

    ////////////////////////////////////////////////////////////
    task automatic close_out;
        if (errTotal == 0 && samplesChecked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errTotal++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [17:0] peek(input logic [19:0] k);
        peek = refMem.exists(k) ? refMem[k] : 'x;
    endfunction : peek

    function automatic logic [17:0] merge(input logic [17:0] old, input logic [17:0] nw, input logic [1:0] beN);
        merge = old;
        for (int i = 0; i < 2; i++)
            if (!beN[i]) merge[9*i +: 9] = nw[9*i +: 9];
    endfunction : merge

    task automatic op(input logic rd, input logic [3:0] a, input logic [3:0] be);
        @(posedge clock);
        reqOn   <= 1'b1;
        reqRead <= rd;
        reqAddr <= base | 20'(a);
        reqData <= {4'($urandom()), $urandom()};
        reqBeN  <= be;
    endtask : op

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clock);
            reqOn   <= 1'b0;
            reqRead <= 1'($urandom());
            reqAddr <= 20'($urandom());
        end
    endtask : idle

    ////////////////////////////////////////////////////////////
    // read expectation is taken before the pending write lands: no forwarding;
    // pipe[0] holds the read taken at the last edge, so bypass looks at 0, normal at 1
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            errTotal++;
            close_out();
        end else if (srst) begin
            pipe = '{default: '0};
            wPend = 0;
            echoExp = 0;
        end else if (ce) begin
            echoExp = !echoExp;
            pipe[2] = pipe[1];
            pipe[1] = pipe[0];
            pipe[0] = '0;
            if (!cmdLoadN && readWriteSel)
                pipe[0] = '{1'b1, peek(addr), peek(addr ^ 20'h0_0001)};
            if (wPend) begin
                refMem[wAddr] = merge(peek(wAddr), dqIn0, byteEnBeat0N);
                refMem[wAddr ^ 20'h0_0001] = merge(peek(wAddr ^ 20'h0_0001), dqIn1, byteEnBeat1N);
            end
            wPend = !cmdLoadN && !readWriteSel;
            wAddr = addr;
        end
    end

    always @(negedge clock) begin
        if (!srst) begin
            check("dqOe", 18'(pipe[lat].v), 18'(dqOe));
            check("readValidOut", 18'(pipe[lat].v), 18'(readValidOut));
            check("echoClk", 18'(echoExp), 18'(echoClk));
            if (pipe[lat].v) begin
                check("dqOut0", pipe[lat].d0, dqOut0);
                check("dqOut1", pipe[lat].d1, dqOut1);
            end
        end
    end

    ////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(81));
        base = 20'($urandom() & 32'h000F_FFF0);
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < 16; i += 2)
            op(1'b0, 4'(i), 4'h0);
        for (int b = 0; b < 16; b++) begin
            op(1'b1, 4'h6, 4'h0);
            op(1'b0, 4'h6, 4'(b));
            op(1'b1, 4'h7, 4'h0);
        end
        repeat (300) begin
            if ($urandom() % 4 == 0)
                idle(1 + $urandom() % 3);
            else
                op(1'($urandom()), 4'($urandom()), 4'($urandom()));
        end
        idle(4);
        ce <= 1'b0;
        repeat (5) op(1'($urandom()), 4'($urandom()), 4'($urandom()));
        idle(1);
        ce <= 1'b1;
        idle(4);
        dllOffN <= 1'b0;
        lat = 0;
        repeat (100) op(1'($urandom()), 4'($urandom()), 4'($urandom()));
        idle(4);
        dllOffN <= 1'b1;
        lat = 1;
        srst <= 1'b1;
        idle(2);
        srst <= 1'b0;
        op(1'b1, 4'h2, 4'h0);
        op(1'b1, 4'h5, 4'h0);
        idle(4);
        close_out();
    end
endmodule : burst2_ddr_sram_cmd_port_bench
`default_nettype wire
